//--- core/ddd_params.svh
/*
  Constants for the dynamic digital delay block: channel count, field widths,
  limits and state codes.
  Assumes it is included by its bare name from the package and the core.
*/
`ifndef DDD_PARAMS_SVH
`define DDD_PARAMS_SVH
`define DDD_NCH 4
`define DDD_SEL_W 2
`define DDD_DIV_W 11
`define DDD_DLY_W 10
`define DDD_CNT_W 12
`define DDD_ZERO_W 14
`define DDD_MIN_HALF 11'h009
`define DDD_ZERO_NUM 13'h0010
`define DDD_ZERO_SUB 14'h0017
`define DDD_ST_IDLE 2'h0
`define DDD_ST_WAIT 2'h1
`define DDD_ST_RUN 2'h3
`endif

//--- core/ddd_pkg.sv
/*
  Types of the dynamic digital delay block.
  Assumes ddd_params.svh is on the include path.
*/
`include "ddd_params.svh"
package ddd_pkg;
  typedef struct packed {
    logic sync_en;
    logic [`DDD_DIV_W-1:0] divide;
    logic [`DDD_DLY_W-1:0] ddly;
    logic hs;
  } ddd_chan_cfg_t;

  typedef enum logic [1:0] {
    DDD_IDLE = `DDD_ST_IDLE,
    DDD_WAIT = `DDD_ST_WAIT,
    DDD_RUN = `DDD_ST_RUN
  } ddd_state_t;
endpackage

//--- core/ddd_core.sv
/*
  Dynamic digital delay core: per-channel output dividers that are held off
  and restarted a programmed number of half periods after a qualifying edge.
  Assumes mclk_i ticks once per half period of the distribution-path clock and
  that configuration and resync inputs are synchronous to mclk_i.
*/
// Functional notes
// - unsynchronised outputs keep running; synced ones are forced low at the qualifying edge, which can cut a high phase short
// - one mclk cycle is the smallest step: half a distribution-path period
// - delay is whole-step count minus half when half-step bit is set
// - qualifying reference is the output chosen by qualifying_clock_select
// - same output as reference and target shifts again on each resync
// - zero-offset delay depends only on qualifying divide, usable on any output
// - delays below 4.5 periods are raised to 4.5
// - each 0.5 change of delay above 4.5 moves the output by exactly one step
// - a longer equivalent delay keeps the output off for longer
`include "ddd_params.svh"
module ddd_core
  import ddd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire ddd_chan_cfg_t chan_cfg_i [`DDD_NCH],
  input wire logic [`DDD_SEL_W-1:0] qualifying_clock_select_i,
  input wire logic resync_i,
  output logic [`DDD_NCH-1:0] clk_o,
  output logic [`DDD_NCH-1:0] delay_clamped_o,
  output logic [`DDD_ZERO_W-1:0] zero_delay_half_o,
  output logic busy_o
);

  ddd_state_t state;
  logic [`DDD_CNT_W-1:0] cnt [`DDD_NCH];
  logic [`DDD_DIV_W-1:0] hold_cnt [`DDD_NCH];
  logic [`DDD_NCH-1:0] holding;
  logic [`DDD_NCH-1:0] wrap;
  logic ref_edge;

  function automatic logic [`DDD_DIV_W-1:0] eff_div(input ddd_chan_cfg_t c);
    // a divide of zero would stall the counter, so it acts as one
    eff_div = (c.divide == '0) ? `DDD_DIV_W'(1) : c.divide;
  endfunction

  // delay in half periods: 2*count - half_step, floored at the minimum
  function automatic logic [`DDD_DIV_W-1:0] raw_half(input ddd_chan_cfg_t c);
    // a zero count with the half step would wrap to a huge delay; treat it as zero so the floor applies
    raw_half = (c.ddly == '0) ? '0 : ({c.ddly, 1'b0} - `DDD_DIV_W'(c.hs));
  endfunction

  function automatic logic [`DDD_DIV_W-1:0] half_len(input ddd_chan_cfg_t c);
    half_len = (raw_half(c) < `DDD_MIN_HALF) ? `DDD_MIN_HALF : raw_half(c);
  endfunction

  // ceiling by add-and-divide; the half-period unit doubles every term so no fractions remain
  function automatic logic [`DDD_ZERO_W-1:0] zero_half(input logic [`DDD_DIV_W-1:0] d);
    logic [`DDD_ZERO_W-1:0] q;
    logic [`DDD_ZERO_W-1:0] dz;
    dz = `DDD_ZERO_W'(d);
    q = (`DDD_ZERO_W'(`DDD_ZERO_NUM) + dz - `DDD_ZERO_W'(1)) / dz;
    zero_half = `DDD_ZERO_W'(({q[`DDD_ZERO_W-2:0], 1'b1} * dz)) - `DDD_ZERO_SUB;
  endfunction

  // a held channel shows no phase point, so a relative resync cannot retrigger itself
  always_comb begin
    for (int i = 0; i < `DDD_NCH; i++) begin
      wrap[i] = (cnt[i] == '0) && !holding[i];
    end
  end

  assign ref_edge = wrap[qualifying_clock_select_i];
  assign busy_o = (state != DDD_IDLE);

  // resync requests are only looked at in idle, so a request while busy is dropped
  // resync sequencing: wait for the qualifying edge, then let the hold counters run
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= DDD_IDLE;
    end else begin
      case (state)
        DDD_IDLE: begin
          if (resync_i) begin
            state <= DDD_WAIT;
          end
        end
        DDD_WAIT: begin
          if (ref_edge) begin
            state <= DDD_RUN;
          end
        end
        DDD_RUN: begin
          if (holding == '0) begin
            state <= DDD_IDLE;
          end
        end
        default: state <= DDD_IDLE;
      endcase
    end
  end

  // hold counters; unselected channels are never touched so they run on
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      holding <= '0;
      for (int i = 0; i < `DDD_NCH; i++) begin
        hold_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `DDD_NCH; i++) begin
        if (state == DDD_WAIT && ref_edge && chan_cfg_i[i].sync_en) begin
          holding[i] <= 1'b1;
          hold_cnt[i] <= half_len(chan_cfg_i[i]) - `DDD_DIV_W'(1);
        end else if (holding[i]) begin
          hold_cnt[i] <= hold_cnt[i] - `DDD_DIV_W'(1);
          if (hold_cnt[i] == `DDD_DIV_W'(1)) begin
            holding[i] <= 1'b0;
          end
        end
      end
    end
  end

  // output dividers, 50% duty in half-period ticks
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < `DDD_NCH; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `DDD_NCH; i++) begin
        if (holding[i]) begin
          cnt[i] <= '0;
        end else if (cnt[i] >= {eff_div(chan_cfg_i[i]), 1'b0} - `DDD_CNT_W'(1)) begin
          cnt[i] <= '0;
        end else begin
          cnt[i] <= cnt[i] + `DDD_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_o <= '0;
      delay_clamped_o <= '0;
    end else begin
      for (int i = 0; i < `DDD_NCH; i++) begin
        // the held channel stays low, so the delay shows as extra off time
        clk_o[i] <= !holding[i] && (cnt[i] < `DDD_CNT_W'(eff_div(chan_cfg_i[i])));
        delay_clamped_o[i] <= raw_half(chan_cfg_i[i]) < `DDD_MIN_HALF;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      zero_delay_half_o <= '0;
    end else begin
      zero_delay_half_o <= zero_half(eff_div(chan_cfg_i[qualifying_clock_select_i]));
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_resync_arms: assert property (state == DDD_IDLE && resync_i |=> state == DDD_WAIT)
    else $error("resync not armed");
  a_run_ends: assert property (state == DDD_RUN && holding == '0 |=> state == DDD_IDLE)
    else $error("run did not end");
  // registered outputs lag one cycle, so the first edge after reset is skipped
  a_zero_value: assert property ($past(arst_n_i) |->
    zero_delay_half_o == $past(zero_half(eff_div(chan_cfg_i[qualifying_clock_select_i]))))
    else $error("zero offset value wrong");

  a_wait_quiet: assert property (state == DDD_WAIT |-> holding == '0)
    else $error("hold active before qualifying edge");
  a_idle_quiet: assert property (state == DDD_IDLE |-> holding == '0)
    else $error("hold active while idle");
  a_wait_to_run: assert property (state == DDD_WAIT && ref_edge |=> state == DDD_RUN)
    else $error("qualifying edge not taken");
  a_busy_hold: assert property (holding != '0 |-> busy_o)
    else $error("busy low during hold");
  a_run_from_wait: assert property (state == DDD_RUN && $past(state != DDD_RUN) |-> $past(state == DDD_WAIT))
    else $error("run entered without wait");

  for (genvar g = 0; g < `DDD_NCH; g++) begin : g_chk
    a_hold_only_sel: assert property ($rose(holding[g]) |-> $past(chan_cfg_i[g].sync_en))
      else $error("unselected channel held");
    a_hold_length: assert property ($rose(holding[g]) |->
      hold_cnt[g] == $past(half_len(chan_cfg_i[g])) - `DDD_DIV_W'(1))
      else $error("hold length wrong");
    a_hold_floor: assert property ($rose(holding[g]) |-> hold_cnt[g] >= `DDD_MIN_HALF - `DDD_DIV_W'(1))
      else $error("hold below minimum");
    a_ref_source: assert property ($rose(holding[g]) |->
      $past(state == DDD_WAIT && cnt[qualifying_clock_select_i] == '0))
      else $error("hold not started by qualifying edge");
    a_held_low: assert property (holding[g] |=> !clk_o[g])
      else $error("held output not low");
    a_restart: assert property (holding[g] && hold_cnt[g] == `DDD_DIV_W'(1) |=> !holding[g] && cnt[g] == '0 ##1 clk_o[g])
      else $error("divider restart wrong");
    a_step_time: assert property ($rose(holding[g]) && hold_cnt[g] == `DDD_DIV_W'(8) |-> holding[g] [*8] ##1 !holding[g])
      else $error("minimum hold not eight cycles after load");

    a_clamp_flag: assert property ($past(arst_n_i) |->
      delay_clamped_o[g] == $past(raw_half(chan_cfg_i[g]) < `DDD_MIN_HALF))
      else $error("clamp flag wrong");
    a_held_zero: assert property (holding[g] |=> cnt[g] == '0)
      else $error("held divider not reset");

    a_unsel_free: assert property (!chan_cfg_i[g].sync_en && !holding[g] |=> !holding[g])
      else $error("unselected channel disturbed");
  end

  c_resync: cover property (state == DDD_WAIT ##1 state == DDD_RUN);
  c_relative: cover property ($rose(holding[qualifying_clock_select_i]));
  c_clamped: cover property (|delay_clamped_o && state == DDD_RUN);
  // a long equivalent delay and a completed resync
  c_long_hold: cover property (state == DDD_RUN && holding[1] && hold_cnt[1] > `DDD_DIV_W'(20));
  c_busy_done: cover property ($fell(busy_o));

endmodule // ddd_core

//--- tb/dynamic_digital_delay_test.sv
/*
  Self-checking bench for the dynamic digital delay core.
  Assumes ddd_params.svh on the include path and ddd_pkg compiled first.
*/
`include "ddd_params.svh"
module dynamic_digital_delay_test
  import ddd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic resync_i = 1'h0;
  ddd_chan_cfg_t cfg [`DDD_NCH];
  logic [`DDD_SEL_W-1:0] qsel = 2'h0;
  logic [`DDD_NCH-1:0] clk_o;
  logic [`DDD_NCH-1:0] clamped;
  logic [`DDD_ZERO_W-1:0] zero_half;
  logic busy;
  int mismatches = 0;
  int compares = 0;

  ddd_core i_ddd_core (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .chan_cfg_i(cfg), .qualifying_clock_select_i(qsel),
    .resync_i(resync_i), .clk_o(clk_o), .delay_clamped_o(clamped), .zero_delay_half_o(zero_half), .busy_o(busy));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // inputs only ever change just after a falling edge
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic test_zero;
    logic [13:0] exp_t [4] = '{14'h001B, 14'h0025, 14'h0010, 14'h0016};
    for (int i = 0; i < 4; i++) begin
      qsel = i[1:0];
      step(2);
      check("zero_delay_half", 32'(zero_half), 32'(exp_t[i]));
    end
  endtask

  task automatic test_clamp;
    step(2);
    check("delay_clamped", 32'(clamped), 32'h9);
  endtask

  // align on a qualifying rise so the next phase point lies one full period later
  task automatic shift(input int q, input int s, input int d, input int dl, input int h, input int l);
    int n;
    logic prev;
    cfg[s].sync_en = 1'h1;
    cfg[s].ddly = dl[9:0];
    cfg[s].hs = h[0];
    qsel = q[1:0];
    step(2);
    n = 0;
    prev = clk_o[q];
    step(1);
    while (!(clk_o[q] === 1'h1 && prev === 1'h0) && n < 200) begin
      prev = clk_o[q];
      step(1);
      n++;
    end
    resync_i = 1'h1;
    step(1);
    resync_i = 1'h0;
    check("busy_taken", 32'(busy), 32'h1);
    step(2 * d);
    for (int i = 1; i < l; i++) begin
      check("held_low", 32'(clk_o[s]), 32'h0);
      step(1);
    end
    check("restart_edge", 32'(clk_o[s]), 32'h1);
    step(2);
    check("busy_done", 32'(busy), 32'h0);
    cfg[s].sync_en = 1'h0;
  endtask

  initial begin
    cfg[0] = '{1'h0, 11'h00A, 10'h004, 1'h1};
    cfg[1] = '{1'h0, 11'h014, 10'h005, 1'h1};
    cfg[2] = '{1'h0, 11'h003, 10'h005, 1'h0};
    cfg[3] = '{1'h0, 11'h005, 10'h004, 1'h0};
    step(12);
    arst_n_i = 1'h1;
    test_zero;
    test_clamp;
    shift(0, 1, 10, 14, 1, 27);
    shift(0, 1, 10, 14, 0, 28);
    shift(0, 2, 10, 4, 1, 9);
    shift(1, 3, 20, 19, 1, 37);
    shift(2, 2, 3, 6, 0, 12);
    shift(2, 2, 3, 6, 0, 12);
    tally_and_finish;
  end

  // whole run is a few hundred cycles; this limit is far beyond it
  initial begin
    #200us;
    mismatches++;
    tally_and_finish;
  end
endmodule // dynamic_digital_delay_test
